// File: include/som_pkg.sv
// Constants, register map and carrier types of the serial output mux
package som_pkg;

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  localparam int          SOM_ADDR_W = 8;
  localparam int          SOM_DATA_W = 24;
  localparam logic [7:0]  SOM_ADDR_EXACT_FREQ = 8'h0c;
  localparam logic [7:0]  SOM_ADDR_SDO_CTRL   = 8'h0f;
  localparam logic [23:0] SOM_RST_EXACT_FREQ  = 24'h000000;
  localparam logic [23:0] SOM_RST_SDO_CTRL    = 24'h000001;

  // ----------------------------------------
  // Field widths
  // ----------------------------------------
  localparam int          SOM_SEL_W  = 5;
  localparam int          SOM_CNT_W  = 14;
  localparam int          SOM_CTRL_W = 10;
  localparam logic [13:0] SOM_CNT_MIN_ACTIVE = 14'h0002;
  localparam int          SOM_SYNC_STAGES    = 2;

  // ----------------------------------------
  // Selector codes
  // ----------------------------------------
  typedef enum logic [4:0] {
    SOM_SEL_STATIC      = 5'h00,
    SOM_SEL_LOCK        = 5'h01,
    SOM_SEL_LOCK_TRIG   = 5'h02,
    SOM_SEL_LOCK_WIN    = 5'h03,
    SOM_SEL_RING_OSC    = 5'h04,
    SOM_SEL_PULL_UP     = 5'h05,
    SOM_SEL_PULL_DOWN   = 5'h06,
    SOM_SEL_RSVD7       = 5'h07,
    SOM_SEL_REF_BUF     = 5'h08,
    SOM_SEL_REF_DIV     = 5'h09,
    SOM_SEL_OSC_DIV     = 5'h0a,
    SOM_SEL_MOD_CLK     = 5'h0b,
    SOM_SEL_AUX_CLK     = 5'h0c,
    SOM_SEL_AUX_SCLK    = 5'h0d,
    SOM_SEL_AUX_SEN     = 5'h0e,
    SOM_SEL_AUX_SDOUT   = 5'h0f,
    SOM_SEL_PD_DOWN     = 5'h10,
    SOM_SEL_PD_UP       = 5'h11,
    SOM_SEL_MOD_DLY     = 5'h12,
    SOM_SEL_MOD_CORE    = 5'h13,
    SOM_SEL_STB_INT     = 5'h14,
    SOM_SEL_STB_FRAC    = 5'h15,
    SOM_SEL_STB_AUX     = 5'h16,
    SOM_SEL_LATCH_EN    = 5'h17,
    SOM_SEL_DIV_SYNC    = 5'h18,
    SOM_SEL_SEED_LOAD   = 5'h19,
    SOM_SEL_DNU_FIRST   = 5'h1a,
    SOM_SEL_DNU_LAST    = 5'h1d,
    SOM_SEL_OUT_BUF_EN  = 5'h1e,
    SOM_SEL_SOFT_RESET  = 5'h1f
  } som_sel_e;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic     low_drive_disable;
    logic     high_drive_disable;
    logic     out_driver_always_on;
    logic     aux_output_only;
    logic     aux_output_static_value;
    som_sel_e aux_output_select;
  } som_ctrl_s;

  typedef struct packed {
    logic lock_detect;
    logic lock_trigger;
    logic lock_window;
    logic ring_osc;
    logic ref_buf;
    logic ref_div;
    logic osc_div;
    logic mod_clk;
    logic aux_clk;
    logic aux_spi_clk;
    logic aux_spi_en;
    logic aux_spi_dout;
    logic pd_down;
    logic pd_up;
    logic mod_clk_delay;
    logic mod_core_clk;
    logic strobe_int_wr;
    logic strobe_frac_wr;
    logic strobe_aux_spi;
    logic spi_latch_en;
    logic osc_div_sync_rst;
    logic seed_load;
    logic out_buf_en;
    logic soft_reset;
  } som_src_s;

endpackage : som_pkg

// File: verilog/som_sync.sv
// Two-stage synchroniser for a vector of independent levels
`timescale 1ns/100ps
`default_nettype none

module som_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  // ----------------------------------------
  // Stages
  // ----------------------------------------
  // Bits are sampled independently; no coherence between bits is implied
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync_out;

  always_comb begin
    next_meta     = async_in;
    next_sync_out = meta;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= next_meta;
      sync_out <= next_sync_out;
    end
  end

endmodule : som_sync
`default_nettype wire

// File: verilog/som_serial_out_mux.sv
// Serial data output pin mux with its control and channel count registers
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Selected signal reaches pin only when enabled
// - Code 0 drives the static test bit
// - Codes 1-3 route lock detect signals
// - Codes 4-6 ring oscillator, weak pulls; 7 reserved
// - Codes 8-11 route reference, divider and modulator clocks
// - Codes 12-15 route auxiliary clock and port
// - Codes 16-19 phase detector and modulator clocks
// - Codes 20-25 route strobes and sync resets
// - Codes 30, 31; host avoids 26-29
// - Bit 6 chooses automux or aux only
// - Bit 7 keeps driver on continuously while enabled, except codes 5, 6
// - Bit 8 disables high-side drive
// - Bit 9 disables low-side drive
// - Count 0 or 1 disables exact mode
module som_serial_out_mux (
  // Clock and reset
  input  wire logic                           clk,
  input  wire logic                           reset,
  // Register port from the serial interface core
  input  wire logic                           reg_wr_en,
  input  wire logic [som_pkg::SOM_ADDR_W-1:0] reg_addr,
  input  wire logic [som_pkg::SOM_DATA_W-1:0] reg_wr_data,
  output var  logic [som_pkg::SOM_DATA_W-1:0] reg_rd_data,
  // Serial read path and pin enable
  input  wire logic                           spi_read_active,
  input  wire logic                           spi_read_data,
  input  wire logic                           pin_enable,
  // Internal signals from other clock domains
  input  wire som_pkg::som_src_s              src,
  // Output pin
  output var  logic                           sdo_out,
  output var  logic                           sdo_oe,
  output var  logic                           sdo_weak_pull_up,
  output var  logic                           sdo_weak_pull_down,
  // Exact frequency status
  output var  logic                           exact_freq_enable,
  output var  logic [som_pkg::SOM_CNT_W-1:0]  channel_count_per_compare
);
  import som_pkg::*;

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function automatic logic som_is_reserved(input som_sel_e sel);
    som_is_reserved = (sel == SOM_SEL_RSVD7) ||
                      ((sel >= SOM_SEL_DNU_FIRST) && (sel <= SOM_SEL_DNU_LAST));
  endfunction : som_is_reserved

  function automatic logic som_is_weak(input som_sel_e sel);
    som_is_weak = (sel == SOM_SEL_PULL_UP) || (sel == SOM_SEL_PULL_DOWN);
  endfunction : som_is_weak

  function automatic logic som_pick(input som_sel_e sel, input logic stat, input som_src_s s);
    case (sel)
      SOM_SEL_STATIC:     som_pick = stat;
      SOM_SEL_LOCK:       som_pick = s.lock_detect;
      SOM_SEL_LOCK_TRIG:  som_pick = s.lock_trigger;
      SOM_SEL_LOCK_WIN:   som_pick = s.lock_window;
      SOM_SEL_RING_OSC:   som_pick = s.ring_osc;
      SOM_SEL_PULL_UP:    som_pick = 1'b1;
      SOM_SEL_PULL_DOWN:  som_pick = 1'b0;
      SOM_SEL_REF_BUF:    som_pick = s.ref_buf;
      SOM_SEL_REF_DIV:    som_pick = s.ref_div;
      SOM_SEL_OSC_DIV:    som_pick = s.osc_div;
      SOM_SEL_MOD_CLK:    som_pick = s.mod_clk;
      SOM_SEL_AUX_CLK:    som_pick = s.aux_clk;
      SOM_SEL_AUX_SCLK:   som_pick = s.aux_spi_clk;
      SOM_SEL_AUX_SEN:    som_pick = s.aux_spi_en;
      SOM_SEL_AUX_SDOUT:  som_pick = s.aux_spi_dout;
      SOM_SEL_PD_DOWN:    som_pick = s.pd_down;
      SOM_SEL_PD_UP:      som_pick = s.pd_up;
      SOM_SEL_MOD_DLY:    som_pick = s.mod_clk_delay;
      SOM_SEL_MOD_CORE:   som_pick = s.mod_core_clk;
      SOM_SEL_STB_INT:    som_pick = s.strobe_int_wr;
      SOM_SEL_STB_FRAC:   som_pick = s.strobe_frac_wr;
      SOM_SEL_STB_AUX:    som_pick = s.strobe_aux_spi;
      SOM_SEL_LATCH_EN:   som_pick = s.spi_latch_en;
      SOM_SEL_DIV_SYNC:   som_pick = s.osc_div_sync_rst;
      SOM_SEL_SEED_LOAD:  som_pick = s.seed_load;
      SOM_SEL_OUT_BUF_EN: som_pick = s.out_buf_en;
      SOM_SEL_SOFT_RESET: som_pick = s.soft_reset;
      default:            som_pick = 1'b0;
    endcase
  endfunction : som_pick

  // ----------------------------------------
  // Synchronised sources
  // ----------------------------------------
  // Fast clocks alias at this rate; the pin shows a sampled view only
  logic [$bits(som_src_s)-1:0] src_sync_bits;
  som_src_s                    src_sync;

  som_sync #(
    .WIDTH ($bits(som_src_s))
  ) u_src_sync (
    .clk      (clk),
    .reset    (reset),
    .async_in (src),
    .sync_out (src_sync_bits)
  );

  assign src_sync = som_src_s'(src_sync_bits);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  som_ctrl_s               ctrl;
  som_ctrl_s               next_ctrl;
  logic [SOM_CNT_W-1:0]    next_count;
  logic                    next_exact_en;
  logic [SOM_DATA_W-1:0]   next_rd_data;

  always_comb begin
    next_ctrl  = ctrl;
    next_count = channel_count_per_compare;
    if (reg_wr_en && (reg_addr == SOM_ADDR_SDO_CTRL)) begin
      next_ctrl = som_ctrl_s'(reg_wr_data[SOM_CTRL_W-1:0]);
    end
    if (reg_wr_en && (reg_addr == SOM_ADDR_EXACT_FREQ)) begin
      next_count = reg_wr_data[SOM_CNT_W-1:0];
    end
    next_exact_en = (next_count >= SOM_CNT_MIN_ACTIVE);
    case (reg_addr)
      SOM_ADDR_SDO_CTRL:   next_rd_data = {{(SOM_DATA_W-SOM_CTRL_W){1'b0}}, ctrl};
      SOM_ADDR_EXACT_FREQ: next_rd_data = {{(SOM_DATA_W-SOM_CNT_W){1'b0}}, channel_count_per_compare};
      default:             next_rd_data = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl                      <= som_ctrl_s'(SOM_RST_SDO_CTRL[SOM_CTRL_W-1:0]);
      channel_count_per_compare <= SOM_RST_EXACT_FREQ[SOM_CNT_W-1:0];
      exact_freq_enable         <= 1'b0;
      reg_rd_data               <= '0;
    end else begin
      ctrl                      <= next_ctrl;
      channel_count_per_compare <= next_count;
      exact_freq_enable         <= next_exact_en;
      reg_rd_data               <= next_rd_data;
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  // Drive disables apply to the level actually presented, so a disabled
  // side leaves the pin floating rather than forcing the opposite level
  logic aux_value;
  logic pin_value;
  logic drive_req;
  logic next_sdo_out;
  logic next_sdo_oe;
  logic next_pull_up;
  logic next_pull_down;

  always_comb begin
    aux_value = pin_enable ? som_pick(ctrl.aux_output_select, ctrl.aux_output_static_value, src_sync) : 1'b0;
    if (!ctrl.aux_output_only && spi_read_active) begin
      pin_value = spi_read_data;
    end else begin
      pin_value = aux_value;
    end
    drive_req = spi_read_active || (pin_enable && ctrl.out_driver_always_on);
    next_pull_up   = 1'b0;
    next_pull_down = 1'b0;
    if (pin_enable && (ctrl.aux_output_only || !spi_read_active) && som_is_weak(ctrl.aux_output_select)) begin
      next_pull_up   = (ctrl.aux_output_select == SOM_SEL_PULL_UP);
      next_pull_down = (ctrl.aux_output_select == SOM_SEL_PULL_DOWN);
      drive_req      = 1'b0;
    end
    next_sdo_out = pin_value;
    next_sdo_oe  = drive_req && (pin_value ? !ctrl.high_drive_disable
                                           : !ctrl.low_drive_disable);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sdo_out            <= 1'b0;
      sdo_oe             <= 1'b0;
      sdo_weak_pull_up   <= 1'b0;
      sdo_weak_pull_down <= 1'b0;
    end else begin
      sdo_out            <= next_sdo_out;
      sdo_oe             <= next_sdo_oe;
      sdo_weak_pull_up   <= next_pull_up;
      sdo_weak_pull_down <= next_pull_down;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  logic aux_path;
  assign aux_path = pin_enable && ctrl.aux_output_only;

  pin_disabled_a: assert property (!pin_enable && !spi_read_active |=> !sdo_oe && !sdo_out)
    else $error("pin driven while disabled");
  static_bit_a: assert property (aux_path && ctrl.aux_output_select == SOM_SEL_STATIC
      |=> sdo_out == $past(ctrl.aux_output_static_value))
    else $error("static bit not on pin");
  lock_route_a: assert property (aux_path && ctrl.aux_output_select == SOM_SEL_LOCK_WIN
      |=> sdo_out == $past(src_sync.lock_window))
    else $error("lock window not routed");
  weak_pull_a: assert property (aux_path && ctrl.aux_output_select == SOM_SEL_PULL_UP
      |=> sdo_weak_pull_up && !sdo_weak_pull_down && !sdo_oe)
    else $error("weak pull-up not applied");
  ref_route_a: assert property (aux_path && ctrl.aux_output_select == SOM_SEL_REF_DIV
      |=> sdo_out == $past(src_sync.ref_div))
    else $error("reference divider not routed");
  aux_route_a: assert property (aux_path && ctrl.aux_output_select == SOM_SEL_AUX_SDOUT
      |=> sdo_out == $past(src_sync.aux_spi_dout))
    else $error("aux data not routed");
  pd_route_a: assert property (aux_path && ctrl.aux_output_select == SOM_SEL_PD_UP
      |=> sdo_out == $past(src_sync.pd_up))
    else $error("phase detector up not routed");
  strobe_route_a: assert property (aux_path && ctrl.aux_output_select == SOM_SEL_SEED_LOAD
      |=> sdo_out == $past(src_sync.seed_load))
    else $error("seed strobe not routed");
  reset_route_a: assert property (aux_path && ctrl.aux_output_select == SOM_SEL_SOFT_RESET
      |=> sdo_out == $past(src_sync.soft_reset))
    else $error("soft reset not routed");
  automux_read_a: assert property (!ctrl.aux_output_only && spi_read_active
      |=> sdo_out == $past(spi_read_data))
    else $error("read data not muxed on pin");
  driver_gate_a: assert property (!spi_read_active && !ctrl.out_driver_always_on |=> !sdo_oe)
    else $error("driver on outside read cycle");
  high_off_a: assert property (sdo_oe && sdo_out |-> !$past(ctrl.high_drive_disable))
    else $error("high drive while disabled");
  low_off_a: assert property (sdo_oe && !sdo_out |-> !$past(ctrl.low_drive_disable))
    else $error("low drive while disabled");
  exact_mode_a: assert property (reg_wr_en && reg_addr == SOM_ADDR_EXACT_FREQ
      |=> exact_freq_enable == ($past(reg_wr_data[SOM_CNT_W-1:0]) >= SOM_CNT_MIN_ACTIVE))
    else $error("exact mode enable wrong");
  reserved_low_a: assert property (aux_path && som_is_reserved(ctrl.aux_output_select)
      |=> !sdo_out)
    else $error("reserved code not low");

  // One check per code except 13, 14, 18, 21, 22 and 24, which have no route check
  lock_out_a: assert property (aux_path && ctrl.aux_output_select == SOM_SEL_LOCK
      |=> sdo_out == $past(src_sync.lock_detect))
    else $error("lock detect not routed");
  lock_trig_a: assert property (aux_path && ctrl.aux_output_select == SOM_SEL_LOCK_TRIG
      |=> sdo_out == $past(src_sync.lock_trigger))
    else $error("lock trigger not routed");
  ring_route_a: assert property (aux_path && ctrl.aux_output_select == SOM_SEL_RING_OSC
      |=> sdo_out == $past(src_sync.ring_osc))
    else $error("ring oscillator not routed");
  weak_down_a: assert property (aux_path && ctrl.aux_output_select == SOM_SEL_PULL_DOWN
      |=> sdo_weak_pull_down && !sdo_weak_pull_up && !sdo_oe)
    else $error("weak pull-down not applied");
  refbuf_route_a: assert property (aux_path && ctrl.aux_output_select == SOM_SEL_REF_BUF
      |=> sdo_out == $past(src_sync.ref_buf))
    else $error("reference buffer not routed");
  div_route_a: assert property (aux_path && ctrl.aux_output_select == SOM_SEL_OSC_DIV
      |=> sdo_out == $past(src_sync.osc_div))
    else $error("oscillator divider not routed");
  modclk_route_a: assert property (aux_path && ctrl.aux_output_select == SOM_SEL_MOD_CLK
      |=> sdo_out == $past(src_sync.mod_clk))
    else $error("modulator clock not routed");
  auxclk_route_a: assert property (aux_path && ctrl.aux_output_select == SOM_SEL_AUX_CLK
      |=> sdo_out == $past(src_sync.aux_clk))
    else $error("aux clock not routed");
  pd_down_a: assert property (aux_path && ctrl.aux_output_select == SOM_SEL_PD_DOWN
      |=> sdo_out == $past(src_sync.pd_down))
    else $error("phase detector down not routed");
  core_route_a: assert property (aux_path && ctrl.aux_output_select == SOM_SEL_MOD_CORE
      |=> sdo_out == $past(src_sync.mod_core_clk))
    else $error("modulator core clock not routed");
  int_strobe_a: assert property (aux_path && ctrl.aux_output_select == SOM_SEL_STB_INT
      |=> sdo_out == $past(src_sync.strobe_int_wr))
    else $error("integer strobe not routed");
  latch_route_a: assert property (aux_path && ctrl.aux_output_select == SOM_SEL_LATCH_EN
      |=> sdo_out == $past(src_sync.spi_latch_en))
    else $error("latch enable not routed");
  buf_en_a: assert property (aux_path && ctrl.aux_output_select == SOM_SEL_OUT_BUF_EN
      |=> sdo_out == $past(src_sync.out_buf_en))
    else $error("buffer enable not routed");
  read_drive_a: assert property (spi_read_active && !ctrl.aux_output_only && !ctrl.high_drive_disable
      && !ctrl.low_drive_disable |=> sdo_oe)
    else $error("driver off during read cycle");
  always_on_a: assert property (pin_enable && ctrl.out_driver_always_on && !som_is_weak(ctrl.aux_output_select)
      && !ctrl.high_drive_disable && !ctrl.low_drive_disable |=> sdo_oe)
    else $error("always-on driver not enabled");
  count_store_a: assert property (reg_wr_en && reg_addr == SOM_ADDR_EXACT_FREQ
      |=> channel_count_per_compare == $past(reg_wr_data[SOM_CNT_W-1:0]))
    else $error("channel count not stored");
  exact_level_a: assert property (exact_freq_enable == (channel_count_per_compare >= SOM_CNT_MIN_ACTIVE))
    else $error("exact mode out of step with count");

  read_mux_c: cover property (!ctrl.aux_output_only && spi_read_active ##1 sdo_oe);
  static_high_c: cover property (aux_path && ctrl.aux_output_static_value ##1 sdo_out && sdo_oe);
  exact_on_c: cover property (!exact_freq_enable ##1 exact_freq_enable);
  weak_swap_c: cover property (sdo_weak_pull_up ##1 sdo_weak_pull_down);
  reserved_drive_c: cover property (aux_path && som_is_reserved(ctrl.aux_output_select) ##1 sdo_oe && !sdo_out);

endmodule : som_serial_out_mux
`default_nettype wire

// File: sim/som_host_model.sv
// Host-side model: launches serial read cycles and resolves the pin level
`timescale 1ns/100ps
`default_nettype none

module som_host_model (
  // Clock
  input  wire logic clk,
  // Read cycle requests from the bench
  input  wire logic read_go,
  input  wire logic read_bit,
  output var  logic spi_read_active,
  output var  logic spi_read_data,
  // Pin
  input  wire logic sdo_out,
  input  wire logic sdo_oe,
  input  wire logic sdo_weak_pull_up,
  input  wire logic sdo_weak_pull_down,
  output var  logic pin_level
);
  logic last_level;

  // ----------------------------------------
  // Read cycle, changed only just after an edge
  // ----------------------------------------
  initial begin
    spi_read_active = 1'b0;
    spi_read_data   = 1'b0;
    last_level      = 1'b0;
  end

  always @(posedge clk) begin
    spi_read_active <= read_go;
    spi_read_data   <= read_bit;
    last_level      <= pin_level;
  end

  // ----------------------------------------
  // Pin resolution
  // ----------------------------------------
  // A released pin floats; the inverse of the last level keeps stale data from passing
  always_comb begin
    if (sdo_oe) begin
      pin_level = sdo_out;
    end else if (sdo_weak_pull_up) begin
      pin_level = 1'b1;
    end else if (sdo_weak_pull_down) begin
      pin_level = 1'b0;
    end else begin
      pin_level = ~last_level;
    end
  end
endmodule : som_host_model
`default_nettype wire

// File: sim/tb_som_serial_out_mux.sv
// Self-checking bench for the serial output pin mux
`timescale 1ns/100ps
`default_nettype none

module tb_som_serial_out_mux;
  import som_pkg::*;

  logic        clk;
  logic        reset;
  logic        reg_wr_en;
  logic [7:0]  reg_addr;
  logic [23:0] reg_wr_data;
  logic [23:0] reg_rd_data;
  logic        read_go;
  logic        read_bit;
  logic        spi_read_active;
  logic        spi_read_data;
  logic        pin_enable;
  som_src_s    src;
  logic        sdo_out;
  logic        sdo_oe;
  logic        pull_up;
  logic        pull_down;
  logic        pin_level;
  logic        exact_freq_enable;
  logic [13:0] channel_count_per_compare;
  int          errors;
  int          total_checks;
  logic [23:0] cnt_val [5] = '{24'h000000, 24'h000001, 24'h000002, 24'h003fff, 24'hffffff};

  som_serial_out_mux som_serial_out_mux_i (.clk(clk), .reset(reset), .reg_wr_en(reg_wr_en),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
    .spi_read_active(spi_read_active), .spi_read_data(spi_read_data), .pin_enable(pin_enable),
    .src(src), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .sdo_weak_pull_up(pull_up),
    .sdo_weak_pull_down(pull_down), .exact_freq_enable(exact_freq_enable),
    .channel_count_per_compare(channel_count_per_compare));

  som_host_model som_host_model_i (.clk(clk), .read_go(read_go), .read_bit(read_bit),
    .spi_read_active(spi_read_active), .spi_read_data(spi_read_data), .sdo_out(sdo_out),
    .sdo_oe(sdo_oe), .sdo_weak_pull_up(pull_up), .sdo_weak_pull_down(pull_down), .pin_level(pin_level));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic give_verdict;
    if (errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic reg_write(input logic [7:0] a, input logic [23:0] d);
    @(posedge clk);
    reg_wr_en   <= 1'b1;
    reg_addr    <= a;
    reg_wr_data <= d;
    @(posedge clk);
    reg_wr_en   <= 1'b0;
  endtask : reg_write

  task automatic reg_check(input logic [7:0] a, input logic [23:0] exp);
    @(posedge clk);
    reg_addr <= a;
    @(posedge clk);
    #1;
    chk("reg_rd_data", exp, reg_rd_data);
  endtask : reg_check

  // Source bit of each routed code; -1 where nothing is routed
  function automatic int src_index(input int code);
    if (code >= 1 && code <= 4) return 24 - code;
    if (code >= 8 && code <= 25) return 27 - code;
    if (code >= 30) return 31 - code;
    return -1;
  endfunction : src_index

  function automatic logic [23:0] mk(input int sel, input logic st, ao, aon, hd, ld);
    return {14'h0, ld, hd, aon, ao, st, sel[4:0]};
  endfunction : mk

  // Sync stages plus output register need several edges to settle
  task automatic pin_check(input logic [23:0] ctrl, input logic exp_out, input logic exp_oe);
    reg_write(SOM_ADDR_SDO_CTRL, ctrl);
    repeat (4) @(posedge clk);
    #1;
    chk("sdo_out", {23'h0, exp_out}, {23'h0, sdo_out});
    chk("sdo_oe", {23'h0, exp_oe}, {23'h0, sdo_oe});
  endtask : pin_check

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    give_verdict();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    reset = 1'b1; reg_wr_en = 1'b0; reg_addr = 8'h00; reg_wr_data = 24'h0;
    read_go = 1'b0; read_bit = 1'b0; pin_enable = 1'b0; src = '0;
    errors = 0; total_checks = 0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    reg_check(SOM_ADDR_EXACT_FREQ, SOM_RST_EXACT_FREQ);
    reg_check(SOM_ADDR_SDO_CTRL, SOM_RST_SDO_CTRL);
    reg_check(8'h0d, 24'h000000);
    foreach (cnt_val[i]) begin
      reg_write(SOM_ADDR_EXACT_FREQ, cnt_val[i]);
      #1;
      chk("exact_freq_enable", {23'h0, cnt_val[i][13:0] >= 14'h0002}, {23'h0, exact_freq_enable});
      chk("channel_count_per_compare", {10'h0, cnt_val[i][13:0]}, {10'h0, channel_count_per_compare});
      reg_check(SOM_ADDR_EXACT_FREQ, {10'h0, cnt_val[i][13:0]});
    end
    @(posedge clk);
    pin_enable <= 1'b1;
    for (int c = 0; c < 32; c++) begin
      if (c == 5 || c == 6) continue;
      @(posedge clk);
      src <= '1;
      pin_check(mk(c, 1, 1, 1, 0, 0), (c == 0) || (src_index(c) >= 0), 1);
      @(posedge clk);
      src <= ~(24'h1 << ((src_index(c) < 0) ? 0 : src_index(c)));
      pin_check(mk(c, 0, 1, 1, 0, 0), 0, 1);
    end
    for (int c = 5; c < 7; c++) begin
      pin_check(mk(c, 0, 1, 1, 0, 0), c == 5, 0);
      chk("pull_up", {23'h0, c == 5}, {23'h0, pull_up});
      chk("pull_down", {23'h0, c == 6}, {23'h0, pull_down});
      chk("pin_level", {23'h0, c == 5}, {23'h0, pin_level});
    end
    @(posedge clk);
    src      <= '0;
    read_go  <= 1'b1;
    read_bit <= 1'b1;
    pin_check(mk(0, 0, 0, 1, 0, 0), 1, 1);
    pin_check(mk(0, 0, 1, 1, 0, 0), 0, 1);
    pin_check(mk(0, 1, 1, 0, 0, 0), 1, 1);
    @(posedge clk);
    read_go <= 1'b0;
    pin_check(mk(0, 1, 1, 0, 0, 0), 1, 0);
    pin_check(mk(0, 1, 1, 1, 1, 0), 1, 0);
    pin_check(mk(0, 0, 1, 1, 1, 0), 0, 1);
    pin_check(mk(0, 0, 1, 1, 0, 1), 0, 0);
    pin_check(mk(0, 1, 1, 1, 0, 1), 1, 1);
    @(posedge clk);
    pin_enable <= 1'b0;
    pin_check(mk(0, 1, 1, 1, 0, 0), 0, 0);
    reg_write(SOM_ADDR_SDO_CTRL, 24'hffffff);
    reg_check(SOM_ADDR_SDO_CTRL, 24'h0003ff);
    @(posedge clk);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    reg_check(SOM_ADDR_SDO_CTRL, SOM_RST_SDO_CTRL);
    reg_check(SOM_ADDR_EXACT_FREQ, SOM_RST_EXACT_FREQ);
    give_verdict();
  end
endmodule : tb_som_serial_out_mux
`default_nettype wire
